//--- bmf_pkg.sv
// bmf_pkg: shared constants, register map and helper functions of the
// bus-matching fifo. assumes a single 20 MHz clock domain.
package bmf_pkg;
    // data path shape
    localparam int DATA_W      = 36;
    localparam int BYTE_W      = 9;
    localparam int LANES       = 4;
    localparam int DEPTH_WORDS = 65536;
    localparam int OFF_W       = 16;

    // byte counts of the three port widths
    localparam logic [2:0] BYTES_X36 = 3'h4;
    localparam logic [2:0] BYTES_X18 = 3'h2;
    localparam logic [2:0] BYTES_X9  = 3'h1;

    // register byte addresses
    localparam logic [7:0] REG_STATUS    = 8'h00;
    localparam logic [7:0] REG_CONFIG    = 8'h04;
    localparam logic [7:0] REG_EMPTY_OFF = 8'h08;
    localparam logic [7:0] REG_FULL_OFF  = 8'h0c;
    localparam logic [7:0] REG_COUNT     = 8'h10;

    // status bits (flag pins as driven, active low, plus active high output valid)
    localparam int ST_EMPTY = 0;
    localparam int ST_FULL  = 1;
    localparam int ST_HALF  = 2;
    localparam int ST_AE    = 3;
    localparam int ST_AF    = 4;
    localparam int ST_VALID = 5;

    // config bits
    localparam int CF_BIG    = 0;
    localparam int CF_FALL_THROUGH_SELECT   = 1;
    localparam int CF_INTER  = 2;
    localparam int CF_SERIAL = 3;
    localparam int CF_PICK   = 4;
    localparam int CF_WBYTES = 8;
    localparam int CF_RBYTES = 12;

    // reset values
    localparam logic [DATA_W-1:0] OUT_RESET = 36'h0;

    // eight default offsets, indexed {load pin, pick hi, pick lo}
    localparam logic [OFF_W-1:0] DEF_OFF_TABLE [8] = '{
        16'h0007, 16'h000f, 16'h001f, 16'h003f,
        16'h007f, 16'h00ff, 16'h01ff, 16'h03ff};

    // write port width from the three width straps
    function automatic logic [2:0] write_bytes(input logic bm, input logic iw,
                                               input logic ow);
        if (!bm || !iw)
            return BYTES_X36;
        return ow ? BYTES_X9 : BYTES_X18;
    endfunction

    // read port width from the three width straps
    function automatic logic [2:0] read_bytes(input logic bm, input logic iw,
                                              input logic ow);
        if (!bm || iw)
            return BYTES_X36;
        return ow ? BYTES_X9 : BYTES_X18;
    endfunction

    // bus byte that holds the k-th byte in queue order
    function automatic logic [1:0] lane_byte(input logic [1:0] k, input logic [2:0] n,
                                             input logic big);
        logic [1:0] top;
        top = n[1:0] - 2'h1;
        return big ? top - k : k;
    endfunction

    // offset value carried by a parallel load word
    function automatic logic [31:0] offset_word(input logic [DATA_W-1:0] d,
                                                input logic inter);
        if (inter)
            return {d[34:27], d[25:18], d[16:9], d[7:0]};
        return d[31:0];
    endfunction
endpackage

//--- bmf_store.sv
// bmf_store: byte-wide flop memory with up to four bytes pushed and popped
// per clock. assumes the caller never pushes past full or pops past empty.
`timescale 1ns/1ns
module bmf_store #(
    parameter int AW = 18
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_n,
    input  wire logic [2:0]                  i_push_cnt,
    input  wire logic [bmf_pkg::DATA_W-1:0]  i_push_lanes,
    input  wire logic [2:0]                  i_pop_cnt,
    output logic      [bmf_pkg::DATA_W-1:0]  o_peek,
    output logic      [AW:0]                 o_count
);
    localparam int DEPTH = 1 << AW;

    logic [bmf_pkg::BYTE_W-1:0] mem [DEPTH];
    logic [AW-1:0]              wr_ptr;
    logic [AW-1:0]              rd_ptr;
    logic [AW-1:0]              next_wr_ptr;
    logic [AW-1:0]              next_rd_ptr;
    logic [AW:0]                next_count;

    // pointer and fill arithmetic
    always_comb begin
        next_wr_ptr = wr_ptr + AW'(i_push_cnt);
        next_rd_ptr = rd_ptr + AW'(i_pop_cnt);
        next_count  = o_count + (AW+1)'(i_push_cnt) - (AW+1)'(i_pop_cnt);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            o_count <= '0;
        end else begin
            wr_ptr  <= next_wr_ptr;
            rd_ptr  <= next_rd_ptr;
            o_count <= next_count;
        end
    end

    // byte lanes land at consecutive locations
    always_ff @(posedge i_mclk) begin
        for (int k = 0; k < bmf_pkg::LANES; k++) begin
            if (k < int'(i_push_cnt))
                mem[wr_ptr + AW'(k)] <= i_push_lanes[bmf_pkg::BYTE_W*k +: bmf_pkg::BYTE_W];
        end
    end

    // next four bytes in queue order
    always_comb begin
        for (int k = 0; k < bmf_pkg::LANES; k++)
            o_peek[bmf_pkg::BYTE_W*k +: bmf_pkg::BYTE_W] = mem[rd_ptr + AW'(k)];
    end
endmodule

//--- bmf_cfg.sv
// bmf_cfg: holds the strap selections caught while master reset is low.
// assumes straps stay put after the reset is released.
`timescale 1ns/1ns
module bmf_cfg (
    input  wire logic       i_mclk,
    input  wire logic       i_rst_n,
    input  wire logic       i_width_mode_select,
    input  wire logic       i_write_width_select,
    input  wire logic       i_read_width_select,
    input  wire logic       i_byte_order_select,
    input  wire logic       i_fall_through_serial,
    input  wire logic       i_parity_placement,
    input  wire logic       i_offset_access_enable_n,
    input  wire logic [1:0] i_pick,
    output logic            o_big,
    output logic            o_fall_through_select,
    output logic            o_inter,
    output logic            o_serial,
    output logic [2:0]      o_pick,
    output logic [2:0]      o_wbytes,
    output logic [2:0]      o_rbytes
);
    logic       next_big;
    logic       next_fall_through_select;
    logic       next_inter;
    logic       next_serial;
    logic [2:0] next_pick;
    logic [2:0] next_wbytes;
    logic [2:0] next_rbytes;

    // follow the straps while in reset, freeze afterwards
    always_comb begin
        next_big    = o_big;
        next_fall_through_select   = o_fall_through_select;
        next_inter  = o_inter;
        next_serial = o_serial;
        next_pick   = o_pick;
        next_wbytes = o_wbytes;
        next_rbytes = o_rbytes;
        if (!i_rst_n) begin
            next_big    = !i_byte_order_select;
            next_fall_through_select   = i_fall_through_serial;
            next_inter  = i_parity_placement;
            next_serial = i_offset_access_enable_n;
            next_pick   = {i_offset_access_enable_n, i_pick};
            next_wbytes = bmf_pkg::write_bytes(i_width_mode_select, i_write_width_select,
                                               i_read_width_select);
            next_rbytes = bmf_pkg::read_bytes(i_width_mode_select, i_write_width_select,
                                              i_read_width_select);
        end
    end

    // plain registers, updated every edge
    always_ff @(posedge i_mclk) begin
        o_big    <= next_big;
        o_fall_through_select   <= next_fall_through_select;
        o_inter  <= next_inter;
        o_serial <= next_serial;
        o_pick   <= next_pick;
        o_wbytes <= next_wbytes;
        o_rbytes <= next_rbytes;
    end
endmodule

//--- bmf_top.sv
// bmf_top: bus-matching fifo with strap configuration, shared flag pins,
// programmable almost levels and a small register port.
// assumes writer, reader and register master all run on i_mclk.
//
// Behaviour
// - byte order strap caught during reset
// - three width straps set port widths
// - narrow input widths ignore upper lines
// - standard mode: shared pin shows empty
// - fall-through mode: shared pin shows output valid
// - standard mode: shared pin shows full
// - fall-through mode: shared pin shows space left
// - picks plus load choose default offsets
// - mode pin selects timing during reset
// - mode pin is serial input afterwards
// - half level flag from byte count
// - parity placement strap caught during reset
// - parity placement affects offset loads only
// - load strap selects serial or parallel
// - load redirects accesses to offset registers
// - big endian reads most significant first
// - interspersed parity skips bits 8,17,26,35
// - serial load shifts one bit per edge
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ns
module bmf_top #(
    parameter int DEPTH_WORDS = bmf_pkg::DEPTH_WORDS,
    parameter int OFF_W       = bmf_pkg::OFF_W
) (
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_n,
    input  wire logic                        i_width_mode_select,
    input  wire logic                        i_write_width_select,
    input  wire logic                        i_read_width_select,
    input  wire logic                        i_byte_order_select,
    input  wire logic                        i_default_offset_pick_lo,
    input  wire logic                        i_default_offset_pick_hi,
    input  wire logic                        i_fall_through_serial,
    input  wire logic                        i_parity_placement,
    input  wire logic                        i_offset_access_enable_n,
    input  wire logic                        i_serial_strobe_enable_n,
    input  wire logic                        i_write_enable_n,
    input  wire logic                        i_read_enable_n,
    input  wire logic [bmf_pkg::DATA_W-1:0]  i_data,
    input  wire logic [7:0]                  i_reg_addr,
    input  wire logic [31:0]                 i_reg_wdata,
    input  wire logic                        i_reg_wr,
    input  wire logic                        i_reg_rd,
    output logic      [bmf_pkg::DATA_W-1:0]  o_data,
    output logic                             o_empty_signal_n,
    output logic                             o_full_signal_n,
    output logic                             o_half_level_n,
    output logic                             o_almost_empty_level_n,
    output logic                             o_almost_full_level_n,
    output logic      [31:0]                 o_reg_rdata
);
    localparam int AW = $clog2(DEPTH_WORDS * bmf_pkg::LANES);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] CAP_BYTES  = CW'(DEPTH_WORDS * bmf_pkg::LANES);
    localparam logic [CW-1:0] HALF_BYTES = CW'(DEPTH_WORDS * bmf_pkg::LANES / 2);
    // wide enough for offset times width, even when offsets exceed the depth
    localparam int            PW         = OFF_W + CW;

    logic                       cfg_big;
    logic                       cfg_fall_through_select;
    logic                       cfg_inter;
    logic                       cfg_serial;
    logic [2:0]                 cfg_pick;
    logic [2:0]                 wbytes;
    logic [2:0]                 rbytes;
    logic [CW-1:0]              cnt;
    logic [bmf_pkg::DATA_W-1:0] peek;
    logic [bmf_pkg::DATA_W-1:0] push_lanes;
    logic [2:0]                 push_cnt;
    logic [2:0]                 pop_cnt;
    logic                       ld;
    logic                       can_push;
    logic                       can_pop;
    logic [CW-1:0]              cnt_next;
    logic [CW-1:0]              free_next;
    logic [bmf_pkg::DATA_W-1:0] assembled;
    logic [31:0]                par_word;

    logic                       out_valid;
    logic                       wsel;
    logic                       rsel;
    logic [OFF_W-1:0]           empty_off;
    logic [OFF_W-1:0]           full_off;
    logic [bmf_pkg::DATA_W-1:0] next_o_data;
    logic                       next_out_valid;
    logic                       next_wsel;
    logic                       next_rsel;
    logic [OFF_W-1:0]           next_empty_off;
    logic [OFF_W-1:0]           next_full_off;
    logic                       next_empty_n;
    logic                       next_full_n;
    logic                       next_half_n;
    logic                       next_ae_n;
    logic                       next_af_n;
    logic [31:0]                next_rdata;

    bmf_cfg u_cfg (
        .i_mclk                   (i_mclk),
        .i_rst_n                  (i_rst_n),
        .i_width_mode_select      (i_width_mode_select),
        .i_write_width_select     (i_write_width_select),
        .i_read_width_select      (i_read_width_select),
        .i_byte_order_select      (i_byte_order_select),
        .i_fall_through_serial    (i_fall_through_serial),
        .i_parity_placement       (i_parity_placement),
        .i_offset_access_enable_n (i_offset_access_enable_n),
        .i_pick                   ({i_default_offset_pick_hi, i_default_offset_pick_lo}),
        .o_big                    (cfg_big),
        .o_fall_through_select                   (cfg_fall_through_select),
        .o_inter                  (cfg_inter),
        .o_serial                 (cfg_serial),
        .o_pick                   (cfg_pick),
        .o_wbytes                 (wbytes),
        .o_rbytes                 (rbytes)
    );

    bmf_store #(
        .AW (AW)
    ) u_store (
        .i_mclk       (i_mclk),
        .i_rst_n      (i_rst_n),
        .i_push_cnt   (push_cnt),
        .i_push_lanes (push_lanes),
        .i_pop_cnt    (pop_cnt),
        .o_peek       (peek),
        .o_count      (cnt)
    );

    // write side: only the bytes of the chosen width are queued
    always_comb begin
        ld       = !i_offset_access_enable_n;
        can_push = (CAP_BYTES - cnt) >= CW'(wbytes);
        can_pop  = cnt >= CW'(rbytes);
        push_cnt = (!i_write_enable_n && !ld && can_push) ? wbytes : 3'h0;
        for (int k = 0; k < bmf_pkg::LANES; k++)
            push_lanes[bmf_pkg::BYTE_W*k +: bmf_pkg::BYTE_W] =
                i_data[bmf_pkg::BYTE_W*int'(bmf_pkg::lane_byte(2'(k), wbytes, cfg_big))
                       +: bmf_pkg::BYTE_W];
        par_word = bmf_pkg::offset_word(i_data, cfg_inter);
    end

    // read side: unpack queue bytes onto the output lanes
    always_comb begin
        assembled = '0;
        for (int k = 0; k < bmf_pkg::LANES; k++) begin
            if (k < int'(rbytes))
                assembled[bmf_pkg::BYTE_W*int'(bmf_pkg::lane_byte(2'(k), rbytes, cfg_big))
                          +: bmf_pkg::BYTE_W] =
                    peek[bmf_pkg::BYTE_W*k +: bmf_pkg::BYTE_W];
        end
    end

    // output register, fall-through valid and offset read-back
    always_comb begin
        next_o_data    = o_data;
        next_out_valid = out_valid;
        next_rsel      = rsel;
        pop_cnt        = 3'h0;
        if (!i_rst_n) begin
            next_o_data    = bmf_pkg::OUT_RESET;
            next_out_valid = 1'b0;
            next_rsel      = 1'b0;
        end else if (ld) begin
            if (!i_read_enable_n) begin
                next_o_data = bmf_pkg::DATA_W'(rsel ? full_off : empty_off);
                next_rsel   = !rsel;
            end
        end else if (cfg_fall_through_select) begin
            if (can_pop && (!out_valid || !i_read_enable_n)) begin
                pop_cnt        = rbytes;
                next_o_data    = assembled;
                next_out_valid = 1'b1;
            end else if (!i_read_enable_n) begin
                next_out_valid = 1'b0;
            end
        end else if (!i_read_enable_n && can_pop) begin
            pop_cnt     = rbytes;
            next_o_data = assembled;
        end
    end

    // offset registers: defaults, serial chain, parallel load, software
    always_comb begin
        next_empty_off = empty_off;
        next_full_off  = full_off;
        next_wsel      = wsel;
        if (!i_rst_n) begin
            next_empty_off = OFF_W'(bmf_pkg::DEF_OFF_TABLE[{i_offset_access_enable_n,
                i_default_offset_pick_hi, i_default_offset_pick_lo}]);
            next_full_off  = next_empty_off;
            next_wsel      = 1'b0;
        end else if (ld && cfg_serial && !i_serial_strobe_enable_n) begin
            {next_full_off, next_empty_off} =
                {full_off[OFF_W-2:0], empty_off, i_fall_through_serial};
        end else if (ld && !cfg_serial && !i_write_enable_n) begin
            if (wsel)
                next_full_off = par_word[OFF_W-1:0];
            else
                next_empty_off = par_word[OFF_W-1:0];
            next_wsel = !wsel;
        end else if (i_reg_wr && i_reg_addr == bmf_pkg::REG_EMPTY_OFF) begin
            next_empty_off = i_reg_wdata[OFF_W-1:0];
        end else if (i_reg_wr && i_reg_addr == bmf_pkg::REG_FULL_OFF) begin
            next_full_off = i_reg_wdata[OFF_W-1:0];
        end
    end

    // flags from the count that will stand after this edge
    always_comb begin
        cnt_next     = cnt + CW'(push_cnt) - CW'(pop_cnt);
        free_next    = CAP_BYTES - cnt_next;
        next_empty_n = cfg_fall_through_select ? !next_out_valid : (cnt_next >= CW'(rbytes));
        next_full_n  = cfg_fall_through_select ? !(free_next >= CW'(wbytes))
                                : (free_next >= CW'(wbytes));
        next_half_n  = !(cnt_next > HALF_BYTES);
        next_ae_n    = !(PW'(cnt_next) < PW'(empty_off) * PW'(rbytes));
        next_af_n    = !(PW'(free_next) <= PW'(full_off) * PW'(wbytes));
        if (!i_rst_n) begin
            next_empty_n = i_fall_through_serial;
            next_full_n  = !i_fall_through_serial;
            next_half_n  = 1'b1;
            next_ae_n    = 1'b0;
            next_af_n    = 1'b1;
        end
    end

    // register read port, data only in the cycle after the strobe
    always_comb begin
        next_rdata = 32'h0;
        if (i_rst_n && i_reg_rd) begin
            unique case (i_reg_addr)
                bmf_pkg::REG_STATUS: begin
                    next_rdata[bmf_pkg::ST_EMPTY] = o_empty_signal_n;
                    next_rdata[bmf_pkg::ST_FULL]  = o_full_signal_n;
                    next_rdata[bmf_pkg::ST_HALF]  = o_half_level_n;
                    next_rdata[bmf_pkg::ST_AE]    = o_almost_empty_level_n;
                    next_rdata[bmf_pkg::ST_AF]    = o_almost_full_level_n;
                    next_rdata[bmf_pkg::ST_VALID] = out_valid;
                end
                bmf_pkg::REG_CONFIG: begin
                    next_rdata[bmf_pkg::CF_BIG]    = cfg_big;
                    next_rdata[bmf_pkg::CF_FALL_THROUGH_SELECT]   = cfg_fall_through_select;
                    next_rdata[bmf_pkg::CF_INTER]  = cfg_inter;
                    next_rdata[bmf_pkg::CF_SERIAL] = cfg_serial;
                    next_rdata[bmf_pkg::CF_PICK +: 3]   = cfg_pick;
                    next_rdata[bmf_pkg::CF_WBYTES +: 3] = wbytes;
                    next_rdata[bmf_pkg::CF_RBYTES +: 3] = rbytes;
                end
                bmf_pkg::REG_EMPTY_OFF: next_rdata = 32'(empty_off);
                bmf_pkg::REG_FULL_OFF:  next_rdata = 32'(full_off);
                bmf_pkg::REG_COUNT:     next_rdata = 32'(cnt);
                default:                next_rdata = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        o_data                 <= next_o_data;
        out_valid              <= next_out_valid;
        rsel                   <= next_rsel;
        wsel                   <= next_wsel;
        empty_off              <= next_empty_off;
        full_off               <= next_full_off;
        o_empty_signal_n       <= next_empty_n;
        o_full_signal_n        <= next_full_n;
        o_half_level_n         <= next_half_n;
        o_almost_empty_level_n <= next_ae_n;
        o_almost_full_level_n  <= next_af_n;
        o_reg_rdata            <= next_rdata;
    end

    // checks on the flag, strap and offset behaviour
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    property p_cfg_hold;
        $past(i_rst_n) |-> $stable(cfg_fall_through_select) && $stable(cfg_big) && $stable(wbytes);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("strap copy moved");

    property p_std_empty;
        !cfg_fall_through_select |-> (o_empty_signal_n == (cnt >= CW'(rbytes)));
    endproperty
    a_std_empty: assert property (p_std_empty) else $error("empty flag wrong");

    property p_fall_through_select_ready;
        cfg_fall_through_select |-> (o_empty_signal_n == !out_valid);
    endproperty
    a_fall_through_select_ready: assert property (p_fall_through_select_ready) else $error("ready flag wrong");

    property p_std_full;
        !cfg_fall_through_select |-> (o_full_signal_n == ((CAP_BYTES - cnt) >= CW'(wbytes)));
    endproperty
    a_std_full: assert property (p_std_full) else $error("full flag wrong");

    property p_fall_through_select_space;
        cfg_fall_through_select |-> (o_full_signal_n == ((CAP_BYTES - cnt) < CW'(wbytes)));
    endproperty
    a_fall_through_select_space: assert property (p_fall_through_select_space) else $error("space flag wrong");

    property p_half;
        $past(i_rst_n) |-> (o_half_level_n == (cnt <= HALF_BYTES));
    endproperty
    a_half: assert property (p_half) else $error("half flag wrong");

    property p_ld_redirect;
        ld && !i_write_enable_n |=> cnt <= $past(cnt);
    endproperty
    a_ld_redirect: assert property (p_ld_redirect) else $error("memory written under load");

    property p_serial_shift;
        ld && cfg_serial && !i_serial_strobe_enable_n |=>
            empty_off[0] == $past(i_fall_through_serial) &&
            full_off[0] == $past(empty_off[OFF_W-1]);
    endproperty
    a_serial_shift: assert property (p_serial_shift) else $error("serial shift wrong");
endmodule

//--- bmf_far_end.sv
// bmf_far_end: writer and reader logic facing the fifo data ports.
// assumes one shared clock; changes its outputs only after rising edges.
`timescale 1ns/1ns
module bmf_far_end (
    input  wire logic                       i_mclk,
    output logic                            o_write_enable_n,
    output logic                            o_read_enable_n,
    output logic     [bmf_pkg::DATA_W-1:0]  o_data
);
    // idle levels at time zero
    initial begin
        o_write_enable_n = 1'b1;
        o_read_enable_n  = 1'b1;
        o_data           = '0;
    end
    // one write, released at the edge that takes it; bus shows the inverse once released
    task automatic push(input logic [bmf_pkg::DATA_W-1:0] d);
        @(posedge i_mclk);
        o_write_enable_n <= 1'b0;
        o_data           <= d;
        @(posedge i_mclk);
        o_write_enable_n <= 1'b1;
        o_data           <= ~d;
    endtask
    // one read strobe, released at the edge that takes it
    task automatic pop();
        @(posedge i_mclk);
        o_read_enable_n <= 1'b0;
        @(posedge i_mclk);
        o_read_enable_n <= 1'b1;
    endtask
endmodule

//--- tb_bus_matching_fifo_config_flags.sv
// tb_bus_matching_fifo_config_flags: strap, flag and width checks.
// assumes bmf_far_end drives the data port and a depth of 16 words.
`timescale 1ns/1ns
module tb_bus_matching_fifo_config_flags;
    logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [7:0]  i_reg_addr = '0;
    logic [31:0] i_reg_wdata = '0, o_reg_rdata;
    logic [8:0]  strap = '0;
    logic [35:0] i_data, o_data;
    logic        i_write_enable_n, i_read_enable_n, o_empty_signal_n, o_full_signal_n;
    logic        o_half_level_n, sen_n = 1'b1;
    int          miscompares = 0, check_count = 0, cyc = 0;
    // straps {bm,iw,ow,be,lo,hi,fts,ip,ld_n} held after reset
    bmf_top #(.DEPTH_WORDS(16)) bmf_top_i (.i_mclk, .i_rst_n,
        .i_width_mode_select(strap[8]), .i_write_width_select(strap[7]),
        .i_read_width_select(strap[6]), .i_byte_order_select(strap[5]),
        .i_default_offset_pick_lo(strap[4]), .i_default_offset_pick_hi(strap[3]),
        .i_fall_through_serial(strap[2]), .i_parity_placement(strap[1]),
        .i_offset_access_enable_n(strap[0]), .i_serial_strobe_enable_n(sen_n),
        .i_write_enable_n, .i_read_enable_n, .i_data, .i_reg_addr, .i_reg_wdata,
        .i_reg_wr, .i_reg_rd, .o_data, .o_empty_signal_n, .o_full_signal_n,
        .o_half_level_n, .o_almost_empty_level_n(), .o_almost_full_level_n(),
        .o_reg_rdata);
    bmf_far_end bmf_far_end_i (.i_mclk, .o_write_enable_n(i_write_enable_n),
        .o_read_enable_n(i_read_enable_n), .o_data(i_data));
    // clock and hang ceiling
    always #25 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares++;
            print_verdict();
        end
    end
    // compare and count
    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // register write, one strobe cycle
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_reg_wr    <= 1'b1;
        i_reg_addr  <= a;
        i_reg_wdata <= d;
        @(posedge i_mclk);
        i_reg_wr <= 1'b0;
    endtask
    // register read; data stands in the cycle after the strobe
    task automatic reg_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_mclk);
        i_reg_rd   <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_mclk);
        i_reg_rd <= 1'b0;
        #1;
        check(o_reg_rdata, exp);
    endtask
    // reset for 8 cycles with the given straps
    task automatic boot(input logic [8:0] s);
        @(posedge i_mclk);
        i_rst_n <= 1'b0;
        strap   <= s;
        repeat (8) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_mclk);
        #1;
    endtask
    // standard timing, big endian, x36 in x9 out, fill past full
    task automatic test_std();
        logic [35:0] w;
        w = 36'h123456789;
        boot(9'h141);
        check(o_empty_signal_n, 1'b0);
        check(o_full_signal_n, 1'b1);
        reg_chk(8'h04, 32'h00001449);
        reg_chk(8'h08, 32'h0000007f);
        reg_chk(8'h14, 32'h00000000);
        // three serial shifts of ones through the mode pin
        @(posedge i_mclk);
        sen_n    <= 1'b0;
        strap[0] <= 1'b0;
        strap[2] <= 1'b1;
        repeat (3) @(posedge i_mclk);
        sen_n    <= 1'b1;
        strap[0] <= 1'b1;
        reg_chk(8'h08, 32'h000003ff);
        reg_chk(8'h0c, 32'h000003f8);
        reg_wr(8'h08, 32'h00000002);
        reg_wr(8'h0c, 32'h00000001);
        reg_chk(8'h00, 32'h00000016);
        for (int i = 0; i < 17; i++) begin
            bmf_far_end_i.push(w + 36'(i));
            repeat (2) @(posedge i_mclk);
            #1;
            if (i == 7) check(o_half_level_n, 1'b1);
            if (i == 8) check(o_half_level_n, 1'b0);
            if (i == 14) check(o_full_signal_n, 1'b1);
            if (i == 14) reg_chk(8'h00, 32'h0000000b);
        end
        check(o_full_signal_n, 1'b0);
        reg_chk(8'h10, 32'h00000040);
        for (int i = 0; i < 4; i++) begin
            bmf_far_end_i.pop();
            #1;
            check(o_data[8:0], w[35-9*i -: 9]);
        end
        $display("test_std done");
    endtask
    // fall-through, interspersed parity, parallel offset load
    task automatic test_fall_through_select();
        logic [35:0] w;
        w = 36'h9abcdef01;
        boot(9'h03e);
        check(o_empty_signal_n, 1'b1);
        check(o_full_signal_n, 1'b0);
        reg_chk(8'h04, 32'h00004436);
        reg_chk(8'h08, 32'h0000003f);
        reg_wr(8'h08, 32'h00000005);
        reg_chk(8'h08, 32'h00000005);
        bmf_far_end_i.push(36'h000000300);
        repeat (3) @(posedge i_mclk);
        reg_chk(8'h08, 32'h00000100);
        check(o_empty_signal_n, 1'b1);
        @(posedge i_mclk);
        strap[0] <= 1'b1;
        bmf_far_end_i.push(w);
        repeat (4) @(posedge i_mclk);
        #1;
        check(o_empty_signal_n, 1'b0);
        check(o_data, w);
        check(o_full_signal_n, 1'b0);
        bmf_far_end_i.pop();
        repeat (3) @(posedge i_mclk);
        #1;
        check(o_empty_signal_n, 1'b1);
        $display("test_fall_through_select done");
    endtask
    // counts and verdict
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence
    initial begin
        test_std();
        test_fall_through_select();
        print_verdict();
    end
endmodule
